// >>> src/jfp_regs.vh
`ifndef JFP_REGS_VH
`define JFP_REGS_VH
// ----------------------------------------
// instruction opcodes
// ----------------------------------------
`define JFP_IR_W 4
`define JFP_OP_RESET 4'hc
`define JFP_OP_ENABLE 4'h4
`define JFP_OP_COMMAND 4'h5
`define JFP_OP_PAGELOAD 4'h6
`define JFP_OP_PAGEREAD 4'h7
`define JFP_OP_BYPASS 4'hf
// ----------------------------------------
// data register widths and values
// ----------------------------------------
`define JFP_EN_W 16
`define JFP_CMD_W 15
`define JFP_BYTE_W 8
`define JFP_SIGNATURE 16'ha370
`define JFP_EN_RST 16'h0000
`define JFP_CMD_RST 15'h0000
// ----------------------------------------
// timing
// ----------------------------------------
`define JFP_DISABLE_CLR_CYC 2
`define JFP_PAGELOAD_TCK 11
`define JFP_FIFO_DEPTH 16
`endif

// >>> src/jfp_prog_port.v
`timescale 1ns/1ps
`default_nettype none
`include "jfp_regs.vh"

// ----------------------------------------
// page buffer write fifo
// ----------------------------------------
module jfp_fifo #(
  parameter W = 10,
  parameter D = `JFP_FIFO_DEPTH,
  parameter AW = 4
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  wire full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  wire empty = (wp_q == rp_q);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp_q[AW-1:0]];
  always @(posedge clock) begin
    if (in_valid && !full)
      mem[wp_q[AW-1:0]] <= in_data;
  end
  always @(posedge clock) begin
    if (!rst_n) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full)
        wp_q <= wp_q + 1'b1;
      if (out_ready && !empty)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule // jfp_fifo

// ----------------------------------------
// test port programming logic
// ----------------------------------------
module jfp_prog_port #(
  parameter TIMEOUT_CYC = 64,
  parameter AW = 6
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // test port pins
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo_q,
  output reg tdo_oe_q,
  // enable control
  input wire test_port_enable_fuse,
  input wire disable_bit_set,
  input wire ext_reset_n,
  output reg test_port_disable_bit_q,
  // core reset
  output wire core_reset,
  // flash control
  output reg [`JFP_CMD_W-1:0] flash_cmd_q,
  output reg flash_cmd_upd_q,
  output reg flash_exec_q,
  input wire [`JFP_CMD_W-1:0] flash_result,
  input wire [15:0] flash_word,
  output reg [AW-1:0] word_addr_q,
  input wire addr_preset,
  input wire [AW-1:0] addr_preset_val,
  output reg prog_mode_q,
  // page buffer write stream
  output wire pb_valid,
  input wire pb_ready,
  output wire [AW-1:0] pb_addr,
  output wire pb_high,
  output wire [`JFP_BYTE_W-1:0] pb_data
);
  localparam S_RESET = 4'h0;
  localparam S_IDLE = 4'h1;
  localparam S_SEL_DR = 4'h2;
  localparam S_CAP_DR = 4'h3;
  localparam S_SH_DR = 4'h4;
  localparam S_EX1_DR = 4'h5;
  localparam S_PA_DR = 4'h6;
  localparam S_EX2_DR = 4'h7;
  localparam S_UP_DR = 4'h8;
  localparam S_SEL_IR = 4'h9;
  localparam S_CAP_IR = 4'ha;
  localparam S_SH_IR = 4'hb;
  localparam S_EX1_IR = 4'hc;
  localparam S_PA_IR = 4'hd;
  localparam S_EX2_IR = 4'he;
  localparam S_UP_IR = 4'hf;

  // two-flop synchronisers for the pins
  reg [1:0] tck_s_q;
  reg [1:0] tms_s_q;
  reg [1:0] tdi_s_q;
  reg [1:0] xr_s_q;
  reg tck_d1_q;
  always @(posedge clock) begin
    if (!rst_n) begin
      tck_s_q <= 2'h0;
      tms_s_q <= 2'h0;
      tdi_s_q <= 2'h0;
      xr_s_q <= 2'h3;
      tck_d1_q <= 1'b0;
    end else begin
      tck_s_q <= {tck_s_q[0], tck};
      tms_s_q <= {tms_s_q[0], tms};
      tdi_s_q <= {tdi_s_q[0], tdi};
      xr_s_q <= {xr_s_q[0], ext_reset_n};
      tck_d1_q <= tck_s_q[1];
    end
  end
  wire tck_rise = tck_s_q[1] && !tck_d1_q;
  wire tck_fall = !tck_s_q[1] && tck_d1_q;
  wire tms_i = tms_s_q[1];
  wire tdi_i = tdi_s_q[1];

  // ----------------------------------------
  // port enable
  // ----------------------------------------
  reg [1:0] dis_cnt_q;
  always @(posedge clock) begin
    if (!rst_n) begin
      test_port_disable_bit_q <= 1'b0;
      dis_cnt_q <= 2'h0;
    end else if (test_port_disable_bit_q && !xr_s_q[1]) begin
      dis_cnt_q <= dis_cnt_q + 2'h1;
      if (dis_cnt_q == `JFP_DISABLE_CLR_CYC - 1)
        test_port_disable_bit_q <= 1'b0;
    end else begin
      dis_cnt_q <= 2'h0;
      if (disable_bit_set)
        test_port_disable_bit_q <= 1'b1;
    end
  end
  wire port_on = test_port_enable_fuse && !test_port_disable_bit_q;

  // ----------------------------------------
  // tap controller
  // ----------------------------------------
  reg [3:0] st_q;
  reg [3:0] st_d;
  always @* begin
    case (st_q)
      S_RESET: st_d = tms_i ? S_RESET : S_IDLE;
      S_IDLE: st_d = tms_i ? S_SEL_DR : S_IDLE;
      S_SEL_DR: st_d = tms_i ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: st_d = tms_i ? S_EX1_DR : S_SH_DR;
      S_SH_DR: st_d = tms_i ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: st_d = tms_i ? S_UP_DR : S_PA_DR;
      S_PA_DR: st_d = tms_i ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: st_d = tms_i ? S_UP_DR : S_SH_DR;
      S_UP_DR: st_d = tms_i ? S_SEL_DR : S_IDLE;
      S_SEL_IR: st_d = tms_i ? S_RESET : S_CAP_IR;
      S_CAP_IR: st_d = tms_i ? S_EX1_IR : S_SH_IR;
      S_SH_IR: st_d = tms_i ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: st_d = tms_i ? S_UP_IR : S_PA_IR;
      S_PA_IR: st_d = tms_i ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: st_d = tms_i ? S_UP_IR : S_SH_IR;
      S_UP_IR: st_d = tms_i ? S_SEL_DR : S_IDLE;
      default: st_d = S_RESET;
    endcase
  end

  reg [`JFP_IR_W-1:0] ir_q;
  reg [`JFP_IR_W-1:0] ir_sh_q;
  reg rst_reg_q;
  reg byp_q;
  reg hi_q;
  reg first_q;
  reg run_q;
  // exec waits one clock so the command is applied before it runs
  reg exec_arm_q;
  reg [`JFP_EN_W-1:0] en_q;
  reg [`JFP_CMD_W-1:0] cmd_q;
  reg [15:0] tmo_q;
  wire tck_step = tck_rise && port_on;
  wire is_pl = (ir_q == `JFP_OP_PAGELOAD);
  wire is_pr = (ir_q == `JFP_OP_PAGEREAD);
  wire is_cmd = (ir_q == `JFP_OP_COMMAND);
  wire new_ir = tck_step && (st_q == S_UP_IR);
  wire pl_upd = tck_step && (st_q == S_UP_DR) && is_pl;

  // word address step, shared by page load and page read
  function [AW-1:0] addr_next;
    input [AW-1:0] a;
    begin
      addr_next = a + 1'b1;
    end
  endfunction

  always @(posedge clock) begin
    if (!rst_n) begin
      st_q <= S_RESET;
      ir_q <= `JFP_OP_BYPASS;
      ir_sh_q <= 4'h0;
      byp_q <= 1'b0;
      rst_reg_q <= 1'b0;
      en_q <= `JFP_EN_RST;
      cmd_q <= `JFP_CMD_RST;
      prog_mode_q <= 1'b0;
      flash_cmd_q <= `JFP_CMD_RST;
      flash_cmd_upd_q <= 1'b0;
      flash_exec_q <= 1'b0;
      run_q <= 1'b0;
      exec_arm_q <= 1'b0;
      hi_q <= 1'b0;
      first_q <= 1'b1;
      word_addr_q <= {AW{1'b0}};
    end else begin
      flash_cmd_upd_q <= 1'b0;
      flash_exec_q <= exec_arm_q;
      exec_arm_q <= 1'b0;
      if (addr_preset)
        word_addr_q <= addr_preset_val;
      if (tck_step) begin
        st_q <= st_d;
        // reset register survives st_reset, ir returns to bypass: opcode 0xc never resets us
        if (st_q == S_RESET)
          ir_q <= `JFP_OP_BYPASS;
        if (st_q == S_CAP_IR)
          ir_sh_q <= 4'h1;
        if (st_q == S_SH_IR)
          ir_sh_q <= {tdi_i, ir_sh_q[3:1]};
        if (st_q == S_UP_IR) begin
          ir_q <= ir_sh_q;
          hi_q <= 1'b0;
          first_q <= 1'b1;
        end
        // other opcodes touch only bypass, programming regs stay put
        if (st_q == S_SH_DR) begin
          case (ir_q)
            `JFP_OP_RESET: rst_reg_q <= tdi_i;
            `JFP_OP_ENABLE: en_q <= {tdi_i, en_q[15:1]};
            `JFP_OP_COMMAND: cmd_q <= {tdi_i, cmd_q[14:1]};
            `JFP_OP_PAGELOAD, `JFP_OP_PAGEREAD:
              cmd_q[7:0] <= {tdi_i, cmd_q[7:1]};
            default: byp_q <= tdi_i;
          endcase
        end
        if (st_q == S_CAP_DR) begin
          if (is_cmd)
            cmd_q <= flash_result;
          if (is_pr) begin
            cmd_q[7:0] <= hi_q ? flash_word[15:8] : flash_word[7:0];
            hi_q <= !hi_q;
            if (hi_q)
              word_addr_q <= addr_next(word_addr_q);
          end
          if (!is_cmd && !is_pr)
            byp_q <= 1'b0;
        end
        if (st_q == S_UP_DR) begin
          if (ir_q == `JFP_OP_ENABLE)
            prog_mode_q <= (en_q == `JFP_SIGNATURE);
          if (is_cmd) begin
            flash_cmd_q <= cmd_q;
            flash_cmd_upd_q <= 1'b1;
          end
          if (is_pl) begin
            hi_q <= !hi_q;
            first_q <= 1'b0;
            if (!hi_q && !first_q)
              word_addr_q <= addr_next(word_addr_q);
          end
        end
        // one exec pulse on entry to idle only
        run_q <= (st_d == S_IDLE);
        // an instruction update entering idle must not rerun the command
        if (st_d == S_IDLE && !run_q && is_cmd && prog_mode_q &&
            st_q != S_UP_IR)
          exec_arm_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // reset time-out after release
  // ----------------------------------------
  always @(posedge clock) begin
    if (!rst_n)
      tmo_q <= 16'h0000;
    else if (rst_reg_q || !xr_s_q[1])
      tmo_q <= TIMEOUT_CYC[15:0];
    else if (tmo_q != 0)
      tmo_q <= tmo_q - 16'h0001;
  end

  assign core_reset = rst_reg_q || !xr_s_q[1] || (tmo_q != 0);

  // ----------------------------------------
  // page load: byte into fifo, drained in time
  // ----------------------------------------
  // limitation: a full fifo drops the byte, far side must keep draining
  wire [AW+`JFP_BYTE_W:0] pl_next;
  // address sampled after its pre-increment, so enqueue one clock late
  reg pl_pend_q;
  always @(posedge clock) begin
    if (!rst_n)
      pl_pend_q <= 1'b0;
    else
      pl_pend_q <= pl_upd && prog_mode_q;
  end
  // hi_q has toggled already: the byte written is the opposite half
  wire [AW+`JFP_BYTE_W:0] pl_in = {word_addr_q, !hi_q, cmd_q[7:0]};
  jfp_fifo #(.W(AW+`JFP_BYTE_W+1), .D(`JFP_FIFO_DEPTH), .AW(4)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(pl_pend_q),
    .in_ready(),
    .in_data(pl_in),
    .out_valid(pb_valid),
    .out_ready(pb_ready),
    .out_data(pl_next)
  );
  assign pb_addr = pl_next[AW+`JFP_BYTE_W:`JFP_BYTE_W+1];
  assign pb_high = pl_next[`JFP_BYTE_W];
  assign pb_data = pl_next[`JFP_BYTE_W-1:0];

  // ----------------------------------------
  // serial out, changes on falling tck
  // ----------------------------------------
  always @(posedge clock) begin
    if (!rst_n) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall && port_on) begin
      tdo_oe_q <= (st_q == S_SH_DR) || (st_q == S_SH_IR);
      if (st_q == S_SH_IR)
        tdo_q <= ir_sh_q[0];
      else case (ir_q)
        `JFP_OP_RESET: tdo_q <= rst_reg_q;
        `JFP_OP_ENABLE: tdo_q <= en_q[0];
        `JFP_OP_COMMAND, `JFP_OP_PAGELOAD, `JFP_OP_PAGEREAD:
          tdo_q <= cmd_q[0];
        default: tdo_q <= byp_q;
      endcase
    end
  end
endmodule // jfp_prog_port
`default_nettype wire

// >>> test/jfp_prog_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module jfp_prog_port_assertions #(
  parameter TIMEOUT_CYC = 64,
  parameter AW = 6
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // watched outputs and inputs
  input wire logic ext_reset_n,
  input wire logic test_port_disable_bit_q,
  input wire logic core_reset,
  input wire logic flash_cmd_upd_q,
  input wire logic flash_exec_q,
  input wire logic prog_mode_q,
  input wire logic pb_valid,
  input wire logic pb_ready,
  input wire logic [AW-1:0] pb_addr,
  input wire logic pb_high,
  input wire logic [7:0] pb_data
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic [7:0] run_q;
  logic hi_q;
  logic seen_q;
  always @(posedge clock) begin
    if (!rst_n) begin
      run_q <= 8'h00;
      hi_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      // saturate so a stuck reset cannot wrap the count
      run_q <= !core_reset ? 8'h00 : (run_q == 8'hff ? run_q : run_q + 8'h01);
      if (pb_valid && pb_ready) begin
        hi_q <= pb_high;
        seen_q <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rst_clear;
    $rose(rst_n) |-> !prog_mode_q && !pb_valid && !flash_exec_q;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("dirty reset");
  property p_dis_clr;
    !ext_reset_n [*5] |-> !test_port_disable_bit_q;
  endproperty
  a_dis_clr: assert property (p_dis_clr) else $error("disable kept");
  property p_exec_mode;
    flash_exec_q |-> prog_mode_q;
  endproperty
  a_exec_mode: assert property (p_exec_mode) else $error("exec no mode");
  property p_exec_once;
    flash_exec_q |=> (!flash_exec_q) [*8];
  endproperty
  a_exec_once: assert property (p_exec_once) else $error("exec twice");
  property p_upd_once;
    flash_cmd_upd_q |=> (!flash_cmd_upd_q) [*8];
  endproperty
  a_upd_once: assert property (p_upd_once) else $error("update twice");
  property p_upd_excl;
    flash_cmd_upd_q |-> !flash_exec_q;
  endproperty
  a_upd_excl: assert property (p_upd_excl) else $error("upd with exec");
  property p_pb_hold;
    pb_valid && !pb_ready |=> pb_valid && $stable({pb_addr, pb_high, pb_data});
  endproperty
  a_pb_hold: assert property (p_pb_hold) else $error("beat dropped");
  property p_pb_alt;
    pb_valid && pb_ready && seen_q |-> pb_high != hi_q;
  endproperty
  a_pb_alt: assert property (p_pb_alt) else $error("no alternation");
  property p_low_first;
    pb_valid && pb_ready && !seen_q |-> !pb_high;
  endproperty
  a_low_first: assert property (p_low_first) else $error("high first");
  property p_rst_hold;
    $fell(core_reset) |-> run_q >= TIMEOUT_CYC;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("short reset");
endmodule // jfp_prog_port_assertions
bind jfp_prog_port jfp_prog_port_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC),
  .AW(AW)) jfp_prog_port_assertions_i (.*);
`default_nettype wire

// >>> test/jfp_tester.sv
`timescale 1ns/1ps
`default_nettype none
module jfp_tester (
  // test port pins
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period, phase skewed from the chip clock; rests low after
  task automatic clk(input logic m, d, output logic o);
    tms = m;
    tdi = d;
    #41.3;
    o = tdo;
    tck = 1'b1;
    #38.7;
    tck = 1'b0;
  endtask
  task automatic tlr;
    logic o;
    repeat (5) clk(1'b1, 1'b0, o);
    clk(1'b0, 1'b0, o);
  endtask
  // from idle through capture, shift, update and back to idle
  task automatic scan(input logic ir, input int n, input logic [15:0] d,
                      output logic [15:0] q);
    logic o;
    q = 16'h0000;
    clk(1'b1, 1'b0, o);
    if (ir) clk(1'b1, 1'b0, o);
    clk(1'b0, 1'b0, o);
    clk(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      clk(i == n - 1, d[i], o);
      q[i] = o;
    end
    clk(1'b1, 1'b0, o);
    clk(1'b0, ~d[n-1], o);
  endtask
endmodule // jfp_tester
`default_nettype wire

// >>> test/jfp_prog_port_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "jfp_regs.vh"
module jfp_prog_port_test;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  logic clock, rst_n, fuse, dset, ext_n, apre, pb_ready, pb_valid, pb_high;
  logic dbit, core_reset, upd, exec, pmode, oe;
  logic [14:0] cmd, res;
  logic [15:0] word, q;
  logic [5:0] addr, apv, pb_addr;
  logic [7:0] pb_data;
  logic [14:0] got[$];
  wire tck, tms, tdi, tdo;
  int miscompares, n_checks, n_exec, n_upd, n_oe, cyc;
  jfp_prog_port #(.TIMEOUT_CYC(4)) jfp_prog_port_i (.clock(clock),
    .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo_q(tdo),
    .tdo_oe_q(oe), .test_port_enable_fuse(fuse), .disable_bit_set(dset),
    .ext_reset_n(ext_n), .test_port_disable_bit_q(dbit),
    .core_reset(core_reset), .flash_cmd_q(cmd), .flash_cmd_upd_q(upd),
    .flash_exec_q(exec), .flash_result(res), .flash_word(word),
    .word_addr_q(addr), .addr_preset(apre), .addr_preset_val(apv),
    .prog_mode_q(pmode), .pb_valid(pb_valid), .pb_ready(pb_ready),
    .pb_addr(pb_addr), .pb_high(pb_high), .pb_data(pb_data));
  jfp_tester jfp_tester_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  // flash array stand-in: each byte tells which address it came from
  assign word = {addr, 2'b01, ~addr, 2'b10};
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    if (pb_valid === 1'b1 && pb_ready) got.push_back({pb_addr, pb_high, pb_data});
    if (exec === 1'b1) n_exec++;
    if (upd === 1'b1) n_upd++;
    if (oe === 1'b1) n_oe++;
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      report_and_stop;
    end
  end
  task automatic chk(input string s, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s exp=%h got=%h", s, e, g);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic ir(input logic [3:0] op);
    jfp_tester_i.scan(1'b1, 4, {12'h000, op}, q);
    w(12);
  endtask
  task automatic dr(input int n, input logic [15:0] d);
    jfp_tester_i.scan(1'b0, n, d, q);
    w(12);
  endtask
  task automatic preset(input logic [5:0] a);
    apv = a;
    apre = 1'b1;
    w(1);
    apre = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_ir;
    n_oe = 0;
    ir(`JFP_OP_BYPASS);
    chk("ir_capture", 16'h0001, q);
    chk("oe_shift", 16'h0001, {15'h0, n_oe != 0});
    chk("oe_idle", 16'h0000, {15'h0, oe});
    dr(8, 16'h00a5);
    chk("bypass_out", 16'h004a, q);
    chk("cmd_kept", 16'h0000, {1'b0, cmd});
  endtask
  task automatic t_rreg;
    ir(`JFP_OP_RESET);
    dr(1, 16'h0001);
    chk("core_reset_on", 16'h0001, {15'h0, core_reset});
    dr(1, 16'h0000);
    chk("core_reset_off", 16'h0000, {15'h0, core_reset});
  endtask
  task automatic t_enable;
    ir(`JFP_OP_ENABLE);
    dr(16, `JFP_SIGNATURE ^ 16'h0100);
    chk("pmode_bad", 16'h0000, {15'h0, pmode});
    dr(16, `JFP_SIGNATURE);
    chk("pmode_ok", 16'h0001, {15'h0, pmode});
  endtask
  task automatic t_cmd;
    ir(`JFP_OP_COMMAND);
    res = 15'h1234;
    n_exec = 0;
    n_upd = 0;
    dr(15, 16'h2351);
    chk("cmd", 16'h2351, {1'b0, cmd});
    chk("exec_count", 16'h0001, n_exec[15:0]);
    chk("upd_count", 16'h0001, n_upd[15:0]);
    chk("result", 16'h1234, q);
  endtask
  task automatic t_pload;
    preset(6'h05);
    pb_ready = 1'b0;
    ir(`JFP_OP_PAGELOAD);
    for (int k = 0; k < 17; k++) dr(8, 16'(8'h30 + k));
    pb_ready = 1'b1;
    w(40);
    chk("pb_count", 16'd16, 16'(got.size()));
    for (int k = 0; k < 16; k++)
      chk("pb_beat", {1'b0, 6'(5 + k / 2), k[0], 8'(8'h30 + k)},
          {1'b0, got[k]});
    chk("pb_empty", 16'h0000, {15'h0, pb_valid});
  endtask
  task automatic t_pread;
    logic [5:0] a;
    preset(6'h0a);
    ir(`JFP_OP_PAGEREAD);
    for (int k = 0; k < 4; k++) begin
      a = 6'(10 + k / 2);
      dr(8, 16'h0000);
      chk("rd_byte", {8'h00, k[0] ? {a, 2'b01} : {~a, 2'b10}}, q);
    end
    chk("rd_addr", 16'h000c, {10'h0, addr});
    ir(`JFP_OP_ENABLE);
    dr(16, 16'h0000);
    chk("pmode_exit", 16'h0000, {15'h0, pmode});
  endtask
  task automatic t_dis;
    dset = 1'b1;
    w(1);
    dset = 1'b0;
    w(2);
    chk("dis_set", 16'h0001, {15'h0, dbit});
    ext_n = 1'b0;
    w(1);
    chk("dis_hold", 16'h0001, {15'h0, dbit});
    w(3);
    chk("dis_clr", 16'h0000, {15'h0, dbit});
    w(2);
    chk("dis_stay", 16'h0000, {15'h0, dbit});
    ext_n = 1'b1;
    w(20);
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    {rst_n, dset, apre, res, apv} = '0;
    {fuse, ext_n, pb_ready} = 3'b111;
    w(10);
    rst_n = 1'b1;
    w(4);
    jfp_tester_i.tlr;
    t_ir;
    t_rreg;
    t_enable;
    t_cmd;
    t_pload;
    t_pread;
    t_dis;
    report_and_stop;
  end
endmodule // jfp_prog_port_test
`default_nettype wire
